// *** rtl/spicsl_top.sv ***
// SPI control and status logic: control and control/status registers,
// flag sequences, serial clock generation and edge strobes.
// Assumes an APB master on pclk and a byte shifter that uses the strobes.
//
// How it works
// - Enabled interrupt follows done, fault or overrun flags
// - Output enable resets low, cleared on fault
// - Master select picks mode, cleared on fault
// - Divider enable clear adds divide-by-two, master only
// - Code 100 gives /4, 000 gives /8
// - Code 001 gives /16, 011 gives /128
// - Rate bits ignored in slave mode
// - Clock polarity sets serial clock idle level
// - Clock phase picks first or second capture edge
// - Both ends use same polarity and phase
// - Done flag set when byte transfer ends
// - Done cleared by status access then data access
// - Data writes ignored while done flag unacknowledged
// - Data write during transfer sets collision flag
// - Overrun set when byte ends with done set
// - Status register read clears overrun flag
// - Select low in master mode sets fault
// - Fault cleared by access then control write
// - Fault blocks setting enable and master bits
// - Collision flag never raises the interrupt
// - Output disable removes data output drive
// - Select management picks internal select bit
//
// Added by the designer: register access over APB and the placing of the registers.
`include "spicsl_consts.svh"
module spicsl_top (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic ss_n_pin,
  input wire logic sck_pin,
  input wire logic [7:0] rx_byte,
  output spicsl_pkg::spicsl_pins_s pins,
  output spicsl_pkg::spicsl_shift_s shift,
  output logic irq
);

  function automatic logic [6:0] half_period(input logic [2:0] code);
    logic [6:0] h;
    h = `SPICSL_HALF_DIV8;
    unique case (code)
      3'h4: h = `SPICSL_HALF_DIV4;
      3'h0: h = `SPICSL_HALF_DIV8;
      3'h1: h = `SPICSL_HALF_DIV16;
      3'h6: h = `SPICSL_HALF_DIV32;
      3'h2: h = `SPICSL_HALF_DIV64;
      3'h3: h = `SPICSL_HALF_DIV128;
      3'h5: h = `SPICSL_HALF_DIV8;
      3'h7: h = `SPICSL_HALF_DIV64;
    endcase
    return h;
  endfunction

  spicsl_pkg::spicsl_ctrl_s ctrl_reg, ctrl_next, ctrl_wr;
  spicsl_pkg::spicsl_state_e state_reg, state_next;
  spicsl_pkg::spicsl_pins_s pins_next;
  spicsl_pkg::spicsl_shift_s shift_next;
  logic tdone_reg, tdone_next, tdone_arm_reg, tdone_arm_next;
  logic write_collision_flag_reg, write_collision_flag_next, write_collision_flag_arm_reg, write_collision_flag_arm_next;
  logic ovr_reg, ovr_next;
  logic mode_fault_flag_reg, mode_fault_flag_next, mode_fault_flag_arm_reg, mode_fault_flag_arm_next;
  logic sod_reg, ssm_reg, ssi_reg;
  logic [7:0] rxbuf_reg, rxbuf_next;
  logic [4:0] edge_cnt_reg, edge_cnt_next;
  logic [6:0] div_cnt_reg, div_cnt_next;
  logic sck_lvl_reg, sck_lvl_next, sck_prev_reg;
  logic [1:0] pin_level;

  spicsl_sync #(
    .WIDTH(2),
    .RST_VAL(2'h2)
  ) u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .pin({ss_n_pin, sck_pin}),
    .level(pin_level)
  );

  // APB decode; answer one cycle into the access phase
  wire sel_data = paddr == {2'h0, `SPICSL_IDX_DATA, 2'h0};
  wire sel_ctrl = paddr == {2'h0, `SPICSL_IDX_CTRL, 2'h0};
  wire sel_csr = paddr == {2'h0, `SPICSL_IDX_CSR, 2'h0};
  wire mapped = sel_data | sel_ctrl | sel_csr;
  wire acc_wait = psel & penable & !pready;
  wire acc_done = psel & penable & pready;
  wire wr_data = acc_done & pwrite & sel_data;
  wire rd_data = acc_done & !pwrite & sel_data;
  wire wr_ctrl = acc_done & pwrite & sel_ctrl;
  wire rd_csr = acc_done & !pwrite & sel_csr;
  wire wr_csr = acc_done & pwrite & sel_csr;
  wire acc_csr = rd_csr | wr_csr;
  wire [7:0] csr_view = {tdone_reg, write_collision_flag_reg, ovr_reg, mode_fault_flag_reg,
                         1'b0, sod_reg, ssm_reg, ssi_reg};
  wire [7:0] rd_mux = sel_data ? rxbuf_reg :
                      sel_ctrl ? ctrl_reg :
                      sel_csr ? csr_view : 8'h00;

  // Internal select and mode
  wire ss_ext = pin_level[1];
  wire sck_sync = pin_level[0];
  wire ss_int = ssm_reg ? ssi_reg : ss_ext;
  wire master = ctrl_reg.master_select;
  wire enabled = ctrl_reg.output_enable;
  wire fault = master & !ss_int;
  wire busy = state_reg == spicsl_pkg::st_run;

  // Rate code only drives the master divider
  wire [2:0] rate_code = {ctrl_reg.divider_enable, ctrl_reg.rate_select};
  wire [6:0] half = half_period(rate_code);
  wire master_run = busy & master;
  wire tick = master_run & (div_cnt_reg == half - 7'h01);
  wire slave_active = !master & enabled & !ss_int;
  wire slave_edge = slave_active & (sck_sync != sck_prev_reg);
  wire edge_ev = master ? tick : slave_edge;
  wire [4:0] edge_num = edge_cnt_reg + 5'h01;
  // Same phase on both ends keeps capture edges aligned
  wire capture = edge_ev & (edge_num[0] ^ ctrl_reg.clock_phase);
  wire launch = edge_ev & !capture;
  wire done = edge_ev & (edge_num == `SPICSL_EDGES_PER_BYTE);
  wire abort = !enabled | (master ? fault : ss_int);

  // Data write handling; blocked until the done flag is acknowledged
  wire data_blocked = tdone_reg & !tdone_arm_reg;
  wire write_collision_flag_set = wr_data & busy;
  wire start = wr_data & !busy & !data_blocked & master & enabled & !fault;

  always_comb
  begin
    state_next = state_reg;
    unique case (state_reg)
      spicsl_pkg::st_idle:
        if (start | (slave_edge & !done))
          state_next = spicsl_pkg::st_run;
      spicsl_pkg::st_run:
        if (done | abort)
          state_next = spicsl_pkg::st_idle;
    endcase
  end

  assign edge_cnt_next = (done | abort) ? 5'h00 :
                         edge_ev ? edge_num : edge_cnt_reg;
  assign div_cnt_next = (!master_run | tick | abort) ? 7'h00 :
                        div_cnt_reg + 7'h01;
  assign sck_lvl_next = (abort | !master) ? 1'b0 :
                        tick ? !sck_lvl_reg : sck_lvl_reg;

  // Flags: hardware set wins over any clear in the same cycle
  wire tdone_clr = tdone_arm_reg & (rd_data | wr_data);
  assign tdone_next = done | (tdone_reg & !tdone_clr);
  assign tdone_arm_next = (tdone_clr | !tdone_reg) ? 1'b0 :
                          (acc_csr | tdone_arm_reg);
  wire write_collision_flag_clr = write_collision_flag_arm_reg & rd_data;
  assign write_collision_flag_next = write_collision_flag_set | (write_collision_flag_reg & !write_collision_flag_clr);
  assign write_collision_flag_arm_next = (write_collision_flag_clr | !write_collision_flag_reg) ? 1'b0 :
                         (rd_csr | write_collision_flag_arm_reg);
  assign ovr_next = (done & tdone_reg) | (ovr_reg & !rd_csr);
  // Keep the byte that set the done flag on overrun
  assign rxbuf_next = (done & !tdone_reg) ? rx_byte : rxbuf_reg;
  wire mode_fault_flag_clr = mode_fault_flag_arm_reg & wr_ctrl;
  assign mode_fault_flag_next = fault | (mode_fault_flag_reg & !mode_fault_flag_clr);
  assign mode_fault_flag_arm_next = (mode_fault_flag_clr | !mode_fault_flag_reg) ? 1'b0 :
                         (acc_csr | mode_fault_flag_arm_reg);

  // Control write; fault lets enable and master bits be cleared but not set
  wire mode_fault_flag_lock = mode_fault_flag_reg & !mode_fault_flag_arm_reg;
  always_comb
  begin
    ctrl_wr = spicsl_pkg::spicsl_ctrl_s'(pwdata[7:0]);
    if (mode_fault_flag_lock)
    begin
      ctrl_wr.output_enable = ctrl_wr.output_enable
                              & ctrl_reg.output_enable;
      ctrl_wr.master_select = ctrl_wr.master_select
                              & ctrl_reg.master_select;
    end
    ctrl_next = wr_ctrl ? ctrl_wr : ctrl_reg;
    if (fault)
    begin
      ctrl_next.output_enable = 1'b0;
      ctrl_next.master_select = 1'b0;
    end
  end

  // Pin controls; data output dropped by output disable
  wire nx_master = ctrl_next.master_select;
  wire nx_en = ctrl_next.output_enable;
  wire nx_sod = wr_csr ? pwdata[2] : sod_reg;
  always_comb
  begin
    pins_next.sck_out = ctrl_next.clock_polarity ^ sck_lvl_next;
    pins_next.sck_oe = nx_en & nx_master;
    pins_next.mosi_oe = nx_en & !nx_sod & nx_master;
    pins_next.miso_oe = nx_en & !nx_sod & !nx_master & !ss_int;
    shift_next.load = start;
    shift_next.tx_byte = start ? pwdata[7:0] : shift.tx_byte;
    shift_next.capture = capture;
    shift_next.launch = launch;
  end

  // Write collision only reports status
  wire irq_next = ctrl_next.irq_enable
                  & (tdone_next | mode_fault_flag_next | ovr_next);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end
    else
    begin
      pready <= acc_wait;
      pslverr <= acc_wait & !mapped;
      prdata <= acc_wait ? {24'h00_0000, rd_mux} : prdata;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl_reg <= `SPICSL_CTRL_RST;
      {tdone_reg, write_collision_flag_reg, ovr_reg, mode_fault_flag_reg} <= 4'(`SPICSL_CSR_RST >> 4);
      {sod_reg, ssm_reg, ssi_reg} <= 3'h0;
      {tdone_arm_reg, write_collision_flag_arm_reg, mode_fault_flag_arm_reg} <= 3'h0;
      rxbuf_reg <= `SPICSL_RXBUF_RST;
    end
    else
    begin
      ctrl_reg <= ctrl_next;
      {tdone_reg, write_collision_flag_reg, ovr_reg, mode_fault_flag_reg} <=
        {tdone_next, write_collision_flag_next, ovr_next, mode_fault_flag_next};
      {sod_reg, ssm_reg, ssi_reg} <=
        wr_csr ? pwdata[2:0] : {sod_reg, ssm_reg, ssi_reg};
      {tdone_arm_reg, write_collision_flag_arm_reg, mode_fault_flag_arm_reg} <=
        {tdone_arm_next, write_collision_flag_arm_next, mode_fault_flag_arm_next};
      rxbuf_reg <= rxbuf_next;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_reg <= spicsl_pkg::st_idle;
      edge_cnt_reg <= 5'h00;
      div_cnt_reg <= 7'h00;
      sck_lvl_reg <= 1'b0;
      sck_prev_reg <= 1'b0;
      pins <= '0;
      shift <= '0;
      irq <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      edge_cnt_reg <= edge_cnt_next;
      div_cnt_reg <= div_cnt_next;
      sck_lvl_reg <= sck_lvl_next;
      sck_prev_reg <= sck_sync;
      pins <= pins_next;
      shift <= shift_next;
      irq <= irq_next;
    end
  end

  // Checking helpers
  logic [6:0] gap_reg;
  logic sck_seen_reg;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      gap_reg <= 7'h00;
      sck_seen_reg <= 1'b0;
    end
    else
    begin
      sck_seen_reg <= pins.sck_out;
      gap_reg <= (pins.sck_out != sck_seen_reg || shift.load) ? 7'h00 :
                 gap_reg + 7'h01;
    end
  end

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  chk_irq_masked: assert property (
    !ctrl_reg.irq_enable |-> !irq)
    else $error("interrupt raised while disabled");
  chk_irq_on_flag: assert property (
    (ctrl_reg.irq_enable && (tdone_reg || ovr_reg || mode_fault_flag_reg)) |-> irq)
    else $error("interrupt missing for set flag");
  chk_write_collision_flag_no_irq: assert property (
    (write_collision_flag_reg && !tdone_reg && !ovr_reg && !mode_fault_flag_reg) |-> !irq)
    else $error("collision flag raised interrupt");
  chk_fault_effect: assert property (
    fault |=> (mode_fault_flag_reg && !ctrl_reg.output_enable
               && !ctrl_reg.master_select && !pins.sck_oe))
    else $error("mode fault did not drop to slave");
  chk_divider_rate: assert property (
    (pins.sck_out != sck_seen_reg && $past(state_reg) == spicsl_pkg::st_run
     && ctrl_reg.master_select && $stable(ctrl_reg))
    |-> (gap_reg + 7'h01 == half))
    else $error("serial clock half period wrong");
  chk_slave_no_div: assert property (
    !ctrl_reg.master_select |=> div_cnt_reg == 7'h00)
    else $error("divider ran in slave mode");
  chk_idle_level: assert property (
    (state_reg == spicsl_pkg::st_idle && $past(state_reg) ==
     spicsl_pkg::st_idle) |-> pins.sck_out == ctrl_reg.clock_polarity)
    else $error("serial clock idle level wrong");
  chk_capture_edge: assert property (
    shift.capture |-> (edge_cnt_reg[0] != ctrl_reg.clock_phase
                       || edge_cnt_reg == 5'h00))
    else $error("capture on wrong clock transition");
  chk_done_set: assert property (
    $rose(tdone_reg) |-> $past(done))
    else $error("done flag set without transfer end");
  chk_done_clear: assert property (
    $fell(tdone_reg) |-> $past(tdone_arm_reg && (rd_data || wr_data)))
    else $error("done flag cleared out of sequence");
  chk_blocked_write: assert property (
    (wr_data && data_blocked) |=> !shift.load)
    else $error("data write accepted while blocked");
  chk_write_collision_flag_set: assert property (
    (wr_data && busy) |=> write_collision_flag_reg)
    else $error("collision not flagged");
  chk_write_collision_flag_clear: assert property (
    $fell(write_collision_flag_reg) |-> $past(rd_data && write_collision_flag_arm_reg))
    else $error("collision cleared out of sequence");
  chk_ovr_flag: assert property (
    (done && tdone_reg) |=> (ovr_reg && $stable(rxbuf_reg)))
    else $error("overrun not flagged");
  chk_ovr_clear: assert property (
    (rd_csr && !(done && tdone_reg)) |=> !ovr_reg)
    else $error("overrun not cleared by status read");
  chk_mode_fault_flag_clear: assert property (
    $fell(mode_fault_flag_reg) |-> $past(wr_ctrl && mode_fault_flag_arm_reg))
    else $error("mode fault cleared out of sequence");
  chk_mode_fault_flag_lock: assert property (
    (mode_fault_flag_lock && !ctrl_reg.output_enable) |=> !ctrl_reg.output_enable)
    else $error("enable set during mode fault");
  chk_output_off: assert property (
    sod_reg |-> (!pins.mosi_oe && !pins.miso_oe))
    else $error("data output driven while disabled");
  chk_soft_select: assert property (
    (ssm_reg && !ssi_reg && ctrl_reg.master_select) |=> mode_fault_flag_reg)
    else $error("internal select ignored");

  cov_transfer_done: cover property (done);
  cov_overrun: cover property (done && tdone_reg);
  cov_mode_fault: cover property (fault);
  cov_collision: cover property (write_collision_flag_set);

endmodule

// *** rtl/spicsl_consts.svh ***
// Register indices, reset values and divider counts of the SPI control block.
// Assumes APB with 32-bit data; byte address is four times the index.
`ifndef SPICSL_CONSTS_SVH
`define SPICSL_CONSTS_SVH

`define SPICSL_IDX_DATA 8'h21
`define SPICSL_IDX_CTRL 8'h22
`define SPICSL_IDX_CSR 8'h23

`define SPICSL_CTRL_RST 8'h00
`define SPICSL_CSR_RST 8'h00
`define SPICSL_RXBUF_RST 8'h00

`define SPICSL_HALF_DIV4 7'h02
`define SPICSL_HALF_DIV8 7'h04
`define SPICSL_HALF_DIV16 7'h08
`define SPICSL_HALF_DIV32 7'h10
`define SPICSL_HALF_DIV64 7'h20
`define SPICSL_HALF_DIV128 7'h40

`define SPICSL_EDGES_PER_BYTE 5'h10

`endif

// *** rtl/spicsl_pkg.sv ***
// Types shared by the SPI control block files.
// Field order of the control struct matches the register bit order, bit 7 first.
package spicsl_pkg;

  typedef struct packed {
    logic irq_enable;
    logic output_enable;
    logic divider_enable;
    logic master_select;
    logic clock_polarity;
    logic clock_phase;
    logic [1:0] rate_select;
  } spicsl_ctrl_s;

  typedef struct packed {
    logic sck_out;
    logic sck_oe;
    logic mosi_oe;
    logic miso_oe;
  } spicsl_pins_s;

  typedef struct packed {
    logic load;
    logic [7:0] tx_byte;
    logic capture;
    logic launch;
  } spicsl_shift_s;

  typedef enum logic [1:0] {
    st_idle = 2'b01,
    st_run = 2'b10
  } spicsl_state_e;

endpackage

// *** rtl/spicsl_sync.sv ***
// Pin synchroniser: three flops per bit, output follows once stages 2 and 3
// agree. Assumes pins are asynchronous to pclk.
module spicsl_sync #(
  parameter int WIDTH = 2,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [WIDTH-1:0] pin,
  output logic [WIDTH-1:0] level
);

  logic [WIDTH-1:0] s1_reg;
  logic [WIDTH-1:0] s2_reg;
  logic [WIDTH-1:0] s3_reg;
  logic [WIDTH-1:0] level_next;

  // First stage feeds only the second stage
  assign level_next = (~(s2_reg ^ s3_reg) & s3_reg)
                    | ((s2_reg ^ s3_reg) & level);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      s1_reg <= RST_VAL;
      s2_reg <= RST_VAL;
      s3_reg <= RST_VAL;
      level <= RST_VAL;
    end
    else
    begin
      s1_reg <= pin;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      level <= level_next;
    end
  end

endmodule

// *** verif/spicsl_far_end.sv ***
// Far-end SPI master model: slave select, serial clock and the byte that
// the shifter would assemble. Assumes pclk comes from the bench.
module spicsl_far_end (
  input wire logic pclk,
  output logic ss_n_pin,
  output logic sck_pin,
  output logic [7:0] rx_byte
);
  timeunit 1ns;
  timeprecision 1ns;

  initial
  begin
    ss_n_pin = 1'b1;
    sck_pin = 1'b0;
    rx_byte = 8'h00;
  end

  task automatic select(input logic level);
    @(posedge pclk);
    ss_n_pin <= level;
  endtask

  // Idles low and uses phase 0, as the device is set up
  // Slow edges so the three-flop sync never misses one
  task automatic send_byte(input logic [7:0] b);
    @(posedge pclk);
    rx_byte <= b;
    repeat (16)
    begin
      repeat (8) @(posedge pclk);
      sck_pin <= ~sck_pin;
    end
    repeat (8) @(posedge pclk);
  endtask
endmodule

// *** verif/spicsl_top_tb.sv ***
// Self-checking bench for the SPI control and status block.
// Assumes the far-end model drives select, serial clock and received byte.
`include "spicsl_consts.svh"
module spicsl_top_tb;
  timeunit 1ns;
  timeprecision 1ns;

  localparam logic [11:0] A_DATA = {2'b00, `SPICSL_IDX_DATA, 2'b00};
  localparam logic [11:0] A_CTRL = {2'b00, `SPICSL_IDX_CTRL, 2'b00};
  localparam logic [11:0] A_CSR = {2'b00, `SPICSL_IDX_CSR, 2'b00};

  logic pclk = 1'b0;
  logic presetn;
  logic psel;
  logic penable;
  logic pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic last_err;
  logic ss_n_pin;
  logic sck_pin;
  logic [7:0] rx_byte;
  logic irq;
  spicsl_pkg::spicsl_pins_s pins;
  spicsl_pkg::spicsl_shift_s shift;
  int miscompares = 0;
  int compares = 0;
  int cycles = 0;

  spicsl_top i_spicsl_top (
    .pclk(pclk),
    .presetn(presetn),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .ss_n_pin(ss_n_pin),
    .sck_pin(sck_pin),
    .rx_byte(rx_byte),
    .pins(pins),
    .shift(shift),
    .irq(irq)
  );

  spicsl_far_end i_spicsl_far_end (
    .pclk(pclk),
    .ss_n_pin(ss_n_pin),
    .sck_pin(sck_pin),
    .rx_byte(rx_byte)
  );

  initial
  begin
    forever #20 pclk = ~pclk;
  end

  // Hang guard, well above the longest run
  always @(posedge pclk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      miscompares++;
      finish_test();
    end
  end

  task automatic finish_test();
    if (miscompares == 0 && compares > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic apb(input logic wr, input logic [11:0] addr,
                     input logic [7:0] wd, output logic [31:0] rd);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= addr;
    pwdata <= {24'h0, wd};
    @(posedge pclk);
    penable <= 1'b1;
    // No local limit; pready ends this wait, or the hang guard if it never rises
    do
    begin
      @(posedge pclk);
    end
    while (pready !== 1'b1);
    rd = prdata;
    last_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] addr, input logic [7:0] d);
    logic [31:0] r;
    apb(1'b1, addr, d, r);
  endtask

  task automatic rd_chk(input logic [11:0] addr, input logic [7:0] exp);
    logic [31:0] r;
    apb(1'b0, addr, 8'h00, r);
    check(r, {24'h0, exp});
  endtask

  task automatic wait_irq();
    int n;
    n = 0;
    while (irq !== 1'b1 && n < 3000)
    begin
      @(posedge pclk);
      n++;
    end
  endtask

  // Cycles between two serial clock changes
  task automatic sck_half(output int h);
    logic prev;
    int n;
    prev = pins.sck_out;
    h = 0;
    n = 0;
    while (pins.sck_out === prev && n < 300)
    begin
      @(posedge pclk);
      n++;
    end
    prev = pins.sck_out;
    while (pins.sck_out === prev && h < 300)
    begin
      @(posedge pclk);
      h++;
    end
  endtask

  task automatic t_reset();
    logic [31:0] r;
    rd_chk(A_CTRL, 8'h00);
    rd_chk(A_CSR, 8'h00);
    wr(12'h000, 8'hff);
    apb(1'b0, 12'h000, 8'h00, r);
    check({31'h0, last_err}, 32'h1);
    check(r, 32'h0);
  endtask

  task automatic t_divider();
    logic [2:0] codes [6] = '{3'b100, 3'b000, 3'b001, 3'b110, 3'b010, 3'b011};
    logic [6:0] halves [6] = '{`SPICSL_HALF_DIV4, `SPICSL_HALF_DIV8,
      `SPICSL_HALF_DIV16, `SPICSL_HALF_DIV32, `SPICSL_HALF_DIV64,
      `SPICSL_HALF_DIV128};
    logic [31:0] r;
    int h;
    for (int i = 0; i < 6; i++)
    begin
      wr(A_CTRL, {2'b11, codes[i][2], 3'b100, codes[i][1:0]});
      wr(A_DATA, 8'ha5);
      sck_half(h);
      check(h, {25'h0, halves[i]});
      wait_irq();
      check({31'h0, irq}, 32'h1);
      rd_chk(A_CSR, 8'h80);
      apb(1'b0, A_DATA, 8'h00, r);
      rd_chk(A_CSR, 8'h00);
      check({31'h0, irq}, 32'h0);
    end
  endtask

  task automatic t_collision();
    logic [31:0] r;
    wr(A_CTRL, 8'hf0);
    wr(A_DATA, 8'ha5);
    wr(A_DATA, 8'h5a);
    rd_chk(A_CSR, 8'h40);
    check({31'h0, irq}, 32'h0);
    wait_irq();
    wr(A_DATA, 8'h77);
    rd_chk(A_CSR, 8'hc0);
    apb(1'b0, A_DATA, 8'h00, r);
    repeat (100) @(posedge pclk);
    check({31'h0, irq}, 32'h0);
    rd_chk(A_CSR, 8'h00);
  endtask

  task automatic t_fault();
    wr(A_CTRL, 8'hd0);
    i_spicsl_far_end.select(1'b0);
    wait_irq();
    rd_chk(A_CTRL, 8'h80);
    check({31'h0, pins.sck_oe}, 32'h0);
    i_spicsl_far_end.select(1'b1);
    wr(A_CTRL, 8'hd0);
    rd_chk(A_CTRL, 8'h80);
    rd_chk(A_CSR, 8'h10);
    wr(A_CTRL, 8'hd0);
    rd_chk(A_CSR, 8'h00);
    rd_chk(A_CTRL, 8'hd0);
    check({31'h0, irq}, 32'h0);
  endtask

  task automatic t_pins();
    // Polarity changed only while disabled
    wr(A_CTRL, 8'h00);
    wr(A_CTRL, 8'h18);
    repeat (2) @(posedge pclk);
    check({31'h0, pins.sck_out}, 32'h1);
    check({31'h0, pins.sck_oe}, 32'h0);
    wr(A_CTRL, 8'h58);
    repeat (2) @(posedge pclk);
    check({30'h0, pins.sck_oe, pins.mosi_oe}, 32'h3);
    // Output disable drops the data output
    wr(A_CSR, 8'h04);
    repeat (2) @(posedge pclk);
    check({31'h0, pins.mosi_oe}, 32'h0);
    rd_chk(A_CSR, 8'h04);
    wr(A_CSR, 8'h00);
    wr(A_CTRL, 8'h00);
  endtask

  task automatic t_slave();
    wr(A_CTRL, 8'h43);
    i_spicsl_far_end.select(1'b0);
    repeat (6) @(posedge pclk);
    check({30'h0, pins.sck_oe, pins.miso_oe}, 32'h1);
    i_spicsl_far_end.send_byte(8'h3c);
    rd_chk(A_CSR, 8'h80);
    i_spicsl_far_end.send_byte(8'h5a);
    rd_chk(A_CSR, 8'ha0);
    rd_chk(A_CSR, 8'h80);
    rd_chk(A_DATA, 8'h3c);
    i_spicsl_far_end.select(1'b1);
  endtask

  // Phase 1 master byte: strobe order and count, then soft select fault
  task automatic t_phase();
    logic first;
    int caps;
    int lnch;
    int n;
    logic [31:0] r;
    first = 1'b1;
    caps = 0;
    lnch = 0;
    n = 0;
    wr(A_CTRL, 8'hf4);
    wr(A_DATA, 8'h96);
    @(posedge pclk);
    check({23'h0, shift.load, shift.tx_byte}, 32'h196);
    while (irq !== 1'b1 && n < 200)
    begin
      @(posedge pclk);
      n++;
      if ((shift.capture | shift.launch) === 1'b1 && caps + lnch == 0)
        first = shift.capture;
      caps += shift.capture;
      lnch += shift.launch;
    end
    check(caps, 32'h8);
    check(lnch, 32'h8);
    check({31'h0, first}, 32'h0);
    rd_chk(A_CSR, 8'h80);
    apb(1'b0, A_DATA, 8'h00, r);
    wr(A_CSR, 8'h02);
    rd_chk(A_CSR, 8'h12);
    rd_chk(A_CTRL, 8'ha4);
    wr(A_CSR, 8'h03);
    wr(A_CTRL, 8'h00);
    rd_chk(A_CSR, 8'h03);
    wr(A_CSR, 8'h00);
  endtask

  // Reset in the middle of a slow master byte
  task automatic t_midreset();
    wr(A_CTRL, 8'hd3);
    wr(A_DATA, 8'h5a);
    repeat (100) @(posedge pclk);
    presetn <= 1'b0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    rd_chk(A_CTRL, 8'h00);
    rd_chk(A_CSR, 8'h00);
    check({29'h0, irq, pins.sck_oe, pins.sck_out}, 32'h0);
  endtask

  initial
  begin
    presetn <= 1'b0;
    psel <= 1'b0;
    penable <= 1'b0;
    pwrite <= 1'b0;
    paddr <= 12'h000;
    pwdata <= 32'h0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_divider();
    t_collision();
    t_fault();
    t_pins();
    t_phase();
    t_slave();
    t_midreset();
    finish_test();
  end
endmodule
